// [acmp_pkg.sv]
// Constants shared by the comparator control block and its event detector.
// Assumes an 8-bit core data bus on the 100 MHz system clock.
package acmp_pkg;

    // ****************************************************************
    // Register addresses
    // ****************************************************************
    localparam logic [7:0] ACMP_CSR_ADDR    = 8'h50;
    localparam logic [7:0] ACMP_IO_OFFSET   = 8'h20;
    localparam logic [7:0] ACMP_CSR_IO_ADDR = 8'h30;
    localparam logic [7:0] ACMP_IO_LAST     = 8'h3F;
    localparam logic [7:0] ACMP_DIS_ADDR    = 8'h7F;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int ACMP_B_PWROFF  = 7;
    localparam int ACMP_B_REFSEL  = 6;
    localparam int ACMP_B_RESULT  = 5;
    localparam int ACMP_B_FLAG    = 4;
    localparam int ACMP_B_IRQEN   = 3;
    localparam int ACMP_B_CAPTURE = 2;
    localparam int ACMP_B_EDGE_HI = 1;
    localparam int ACMP_B_EDGE_LO = 0;
    localparam int ACMP_B_POS_OFF = 0;
    localparam int ACMP_B_NEG_OFF = 1;

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [7:0] ACMP_CSR_RESET = 8'h00;
    localparam logic [7:0] ACMP_DIS_RESET = 8'h00;
    localparam logic [7:0] ACMP_UNMAPPED  = 8'h00;
    localparam logic [1:0] ACMP_EDGE_TOGGLE = 2'h0;
    localparam logic [1:0] ACMP_EDGE_RSVD   = 2'h1;
    localparam logic [1:0] ACMP_EDGE_FALL   = 2'h2;
    localparam logic [1:0] ACMP_EDGE_RISE   = 2'h3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int ACMP_SYNC_STAGES = 2;

endpackage : acmp_pkg

// [acmp_evt_if.sv]
// Carrier between the control block and its event detector.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
`default_nettype none

interface acmp_evt_if;
    logic       result;    // Synchronised comparator result
    logic       evt;       // One-cycle selected event
    logic [1:0] edge_sel;  // Event type selection

    modport det (output result, output evt, input edge_sel);
    modport ctl (input result, input evt, output edge_sel);
endinterface : acmp_evt_if

`default_nettype wire

// [acmp_edge.sv]
// Synchroniser and edge detector for the raw comparator output.
// Assumes the raw output is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module acmp_edge
    import acmp_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Raw comparator output
    input  wire logic cmp_raw,
    // Event carrier
    acmp_evt_if.det   ev
);

    // ****************************************************************
    // Synchroniser and previous value
    // ****************************************************************
    logic s1_ff, s2_ff, prev_ff;
    logic nxt_s1, nxt_s2, nxt_prev;

    // Next values of the sampling chain
    always_comb begin
        nxt_s1   = cmp_raw;
        nxt_s2   = s1_ff;
        nxt_prev = s2_ff;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_ff   <= 1'b0;
            s2_ff   <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            s1_ff   <= nxt_s1;
            s2_ff   <= nxt_s2;
            prev_ff <= nxt_prev;
        end
    end

    assign ev.result = s2_ff;

    always_comb begin
        unique case (ev.edge_sel)
            ACMP_EDGE_TOGGLE: ev.evt = s2_ff ^ prev_ff;
            ACMP_EDGE_RSVD:   ev.evt = 1'b0;       // Reserved, no event
            ACMP_EDGE_FALL:   ev.evt = prev_ff & ~s2_ff;
            ACMP_EDGE_RISE:   ev.evt = s2_ff & ~prev_ff;
        endcase
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Refuse a synchroniser depth the chain does not build
    if (ACMP_SYNC_STAGES != 2) begin : g_stage_check
        $error("Only a two-stage synchroniser is built");
    end

    a_sync_latency: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ##2 ev.result == $past(cmp_raw, 2))
        else $error("Result not raw input two cycles late");

    a_rise_event: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ev.edge_sel == ACMP_EDGE_RISE && $rose(ev.result)) |-> ev.evt)
        else $error("Rising edge missed");

    a_reserved_quiet: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ev.edge_sel == ACMP_EDGE_RSVD |-> !ev.evt)
        else $error("Event under reserved code");

    a_toggle_event: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ##1 (ev.edge_sel == ACMP_EDGE_TOGGLE) |->
            ev.evt == (ev.result != $past(ev.result)))
        else $error("Toggle event wrong");

    c_fall_event: cover property (
        @(posedge clk_sys) disable iff (!nrst)
        ev.edge_sel == ACMP_EDGE_FALL && ev.evt);

endmodule : acmp_edge

`default_nettype wire

// [acmp_ctrl.sv]
// Top of the analog comparator control: registers, input steering,
// event flag, interrupt request, capture route and pin input disable.
// Assumes a core data-space byte port and same-clock converter controls.
`timescale 1ns/1ps
`default_nettype none

module acmp_ctrl
    import acmp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // Register port
    input  wire logic [7:0] bus_addr,
    input  wire logic       bus_io,
    input  wire logic       bus_we,
    input  wire logic       bus_re,
    input  wire logic [7:0] bus_wdata,
    output var  logic [7:0] bus_rdata_ff,
    // Converter and processor state
    input  wire logic       mux_borrow_enable,
    input  wire logic       converter_enable,
    input  wire logic [2:0] channel_select,
    input  wire logic       global_irq_enable,
    input  wire logic       irq_ack,
    // Analog side
    input  wire logic       cmp_raw,
    output var  logic       neg_use_channel_ff,
    output var  logic [2:0] neg_channel_ff,
    output var  logic       pos_use_ref_ff,
    output var  logic       comparator_power_off_ff,
    // Interrupt and timer capture
    output var  logic       irq_req_ff,
    output var  logic       capture_in_ff,
    // Digital pin buffers
    input  wire logic       positive_input_pin,
    input  wire logic       negative_input_pin,
    output var  logic [1:0] pin_input_off_ff,
    output var  logic [1:0] pin_readback_ff
);

    acmp_evt_if ev ();

    acmp_edge u_edge (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .cmp_raw (cmp_raw),
        .ev      (ev)
    );

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic [7:0] data_addr;
    logic       hit_csr, hit_dis;

    // I/O addresses sit below the data addresses
    always_comb begin
        data_addr = bus_io ? 8'(bus_addr + ACMP_IO_OFFSET) : bus_addr;
        hit_csr   = bus_io ? (bus_addr == ACMP_CSR_IO_ADDR)
                           : (bus_addr == ACMP_CSR_ADDR);
        hit_dis   = !bus_io && (data_addr == ACMP_DIS_ADDR);
        if (bus_io && bus_addr > ACMP_IO_LAST)
            hit_csr = 1'b0;
    end

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic       pwr_off_ff, ref_sel_ff, flag_ff, irq_en_ff, capture_ff;
    logic [1:0] edge_ff, dis_ff;
    logic       nxt_pwr_off, nxt_ref_sel, nxt_flag, nxt_irq_en, nxt_capture;
    logic [1:0] nxt_edge, nxt_dis;
    logic [7:0] csr_view, nxt_rdata;
    logic       csr_wr;

    assign ev.edge_sel = edge_ff;

    // Next register values and read data
    always_comb begin
        csr_wr      = bus_we && hit_csr;
        nxt_pwr_off = pwr_off_ff;
        nxt_ref_sel = ref_sel_ff;
        nxt_irq_en  = irq_en_ff;
        nxt_capture = capture_ff;
        nxt_edge    = edge_ff;
        nxt_dis     = dis_ff;
        nxt_flag    = flag_ff;
        if (csr_wr) begin
            nxt_pwr_off = bus_wdata[ACMP_B_PWROFF];
            nxt_ref_sel = bus_wdata[ACMP_B_REFSEL];
            nxt_irq_en  = bus_wdata[ACMP_B_IRQEN];
            nxt_capture = bus_wdata[ACMP_B_CAPTURE];
            nxt_edge    = bus_wdata[ACMP_B_EDGE_HI:ACMP_B_EDGE_LO];
        end
        if (bus_we && hit_dis)
            nxt_dis = bus_wdata[ACMP_B_NEG_OFF:ACMP_B_POS_OFF];
        if (csr_wr && bus_wdata[ACMP_B_FLAG])
            nxt_flag = 1'b0;
        if (irq_ack)
            nxt_flag = 1'b0;
        // Selected event sets, winning over clears
        if (ev.evt)
            nxt_flag = 1'b1;
        csr_view = {pwr_off_ff, ref_sel_ff, ev.result, flag_ff,
                    irq_en_ff, capture_ff, edge_ff};
        nxt_rdata = bus_rdata_ff;
        if (bus_re) begin
            if (hit_csr)
                nxt_rdata = csr_view;
            else if (hit_dis)
                nxt_rdata = {6'h00, dis_ff};
            else
                nxt_rdata = ACMP_UNMAPPED;
        end
    end

    // Register storage
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pwr_off_ff   <= ACMP_CSR_RESET[ACMP_B_PWROFF];
            ref_sel_ff   <= ACMP_CSR_RESET[ACMP_B_REFSEL];
            flag_ff      <= ACMP_CSR_RESET[ACMP_B_FLAG];
            irq_en_ff    <= ACMP_CSR_RESET[ACMP_B_IRQEN];
            capture_ff   <= ACMP_CSR_RESET[ACMP_B_CAPTURE];
            edge_ff      <= ACMP_CSR_RESET[ACMP_B_EDGE_HI:ACMP_B_EDGE_LO];
            dis_ff       <= ACMP_DIS_RESET[ACMP_B_NEG_OFF:ACMP_B_POS_OFF];
            bus_rdata_ff <= 8'h00;
        end else begin
            pwr_off_ff   <= nxt_pwr_off;
            ref_sel_ff   <= nxt_ref_sel;
            flag_ff      <= nxt_flag;
            irq_en_ff    <= nxt_irq_en;
            capture_ff   <= nxt_capture;
            edge_ff      <= nxt_edge;
            dis_ff       <= nxt_dis;
            bus_rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************************************
    // Steering, interrupt, capture and pins
    // ****************************************************************
    logic [1:0] pin_s1_ff, pin_s2_ff, nxt_pin_s1, nxt_pin_s2;
    logic       nxt_neg_use, nxt_pos_ref, nxt_irq, nxt_cap_in;
    logic [2:0] nxt_neg_ch;
    logic [1:0] nxt_readback;

    // Next values of the registered outputs
    always_comb begin
        nxt_neg_use  = mux_borrow_enable && !converter_enable;
        nxt_neg_ch   = nxt_neg_use ? channel_select : 3'h0;
        nxt_pos_ref  = ref_sel_ff;
        nxt_irq      = flag_ff && irq_en_ff && global_irq_enable;
        // Result reaches capture only when routed
        nxt_cap_in   = capture_ff && ev.result;
        nxt_pin_s1   = {negative_input_pin, positive_input_pin};
        nxt_pin_s2   = pin_s1_ff;
        // Disabled pins read back as zero
        nxt_readback = pin_s2_ff & ~dis_ff;
    end

    // Output registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            neg_use_channel_ff      <= 1'b0;
            neg_channel_ff          <= 3'h0;
            pos_use_ref_ff          <= 1'b0;
            comparator_power_off_ff <= 1'b0;
            irq_req_ff              <= 1'b0;
            capture_in_ff           <= 1'b0;
            pin_input_off_ff        <= 2'h0;
            pin_readback_ff         <= 2'h0;
            pin_s1_ff               <= 2'h0;
            pin_s2_ff               <= 2'h0;
        end else begin
            neg_use_channel_ff      <= nxt_neg_use;
            neg_channel_ff          <= nxt_neg_ch;
            pos_use_ref_ff          <= nxt_pos_ref;
            comparator_power_off_ff <= pwr_off_ff;
            irq_req_ff              <= nxt_irq;
            capture_in_ff           <= nxt_cap_in;
            pin_input_off_ff        <= dis_ff;
            pin_readback_ff         <= nxt_readback;
            pin_s1_ff               <= nxt_pin_s1;
            pin_s2_ff               <= nxt_pin_s2;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_flag_sets: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ev.evt |=> flag_ff)
        else $error("Event did not set flag");

    a_flag_w1c: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (csr_wr && bus_wdata[ACMP_B_FLAG] && !ev.evt) |=> !flag_ff)
        else $error("Write one did not clear flag");

    a_flag_keeps: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (flag_ff && !irq_ack && !(csr_wr && bus_wdata[ACMP_B_FLAG]))
        |=> flag_ff)
        else $error("Flag lost without clear");

    a_flag_ack: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (irq_ack && !ev.evt) |=> !flag_ff)
        else $error("Vector entry did not clear flag");

    a_irq_gate: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ev.evt && irq_en_ff && global_irq_enable && !irq_ack ##1
        (irq_en_ff && global_irq_enable) |=> irq_req_ff)
        else $error("Interrupt not raised after event");

    a_irq_cause: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        irq_req_ff |-> $past(flag_ff && irq_en_ff && global_irq_enable))
        else $error("Interrupt without cause");

    a_neg_steer: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (!mux_borrow_enable || converter_enable) |=> !neg_use_channel_ff)
        else $error("Channel used while not borrowed");

    a_neg_channel: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (mux_borrow_enable && !converter_enable) |=>
            neg_use_channel_ff && neg_channel_ff == $past(channel_select))
        else $error("Borrowed channel not applied");

    a_capture_off: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !capture_ff |=> !capture_in_ff)
        else $error("Capture fed while route off");

    a_pin_off: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        dis_ff[ACMP_B_POS_OFF] |=> !pin_readback_ff[ACMP_B_POS_OFF])
        else $error("Disabled pin read back nonzero");

    c_irq_raised: cover property (
        @(posedge clk_sys) disable iff (!nrst) $rose(irq_req_ff));
    c_borrowed: cover property (
        @(posedge clk_sys) disable iff (!nrst) neg_use_channel_ff);
    c_capture: cover property (
        @(posedge clk_sys) disable iff (!nrst) $rose(capture_in_ff));

endmodule : acmp_ctrl

`default_nettype wire

// [acmp_analog_model.sv]
// Behavioural far side of the comparator control: analog levels, the
// comparator itself and a timer capture front end that counts events.
// Assumes the bench sets the levels and the control block steers inputs.
`timescale 1ns/1ps
`default_nettype none

module acmp_analog_model #(
    parameter logic [7:0] REF_LEVEL = 8'hC0  // Plain default for bandgap
) (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            nrst,
    // Analog levels set by the bench
    input  wire logic [7:0]      pos_level,
    input  wire logic [7:0]      neg_level,
    input  wire logic [7:0][7:0] chan_level,
    // Steering from the control block
    input  wire logic            neg_use_channel,
    input  wire logic [2:0]      neg_channel,
    input  wire logic            pos_use_ref,
    // Timer capture side
    input  wire logic            capture_in,
    input  wire logic            capture_irq_enable,
    output var  logic [7:0]      capture_count,
    // Comparator and digital pins
    output var  logic            cmp_raw,
    output var  logic            positive_input_pin,
    output var  logic            negative_input_pin
);
    logic [7:0] pos_v;
    logic [7:0] neg_v;
    logic       cap_q;

    // Input steering and comparison
    always_comb begin
        pos_v   = pos_use_ref ? REF_LEVEL : pos_level;
        neg_v   = neg_use_channel ? chan_level[neg_channel] : neg_level;
        cmp_raw = pos_v > neg_v;
        positive_input_pin = pos_level[7];
        negative_input_pin = neg_level[7];
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cap_q         <= 1'b0;
            capture_count <= 8'h00;
        end else begin
            cap_q <= capture_in;
            if (capture_in && !cap_q && capture_irq_enable)
                capture_count <= capture_count + 8'h01;
        end
    end
endmodule // acmp_analog_model

`default_nettype wire

// [acmp_ctrl_tb_top.sv]
// Self-checking bench for the comparator control block.
// Assumes the package, carrier interface and design sources compile first.
`timescale 1ns/1ps
`default_nettype none

module acmp_ctrl_tb_top;
    import acmp_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic            clk_sys, nrst, bus_io, bus_we, bus_re;
    logic [7:0]      bus_addr, bus_wdata, bus_rdata_ff;
    logic            mux_borrow_enable, converter_enable;
    logic [2:0]      channel_select;
    logic            global_irq_enable, irq_ack, cmp_raw;
    logic            neg_use_channel_ff, pos_use_ref_ff;
    logic [2:0]      neg_channel_ff;
    logic            comparator_power_off_ff, irq_req_ff, capture_in_ff;
    logic            positive_input_pin, negative_input_pin;
    logic [1:0]      pin_input_off_ff, pin_readback_ff;
    logic [7:0]      pos_level, neg_level, capture_count;
    logic [7:0][7:0] chan_level;
    int              mismatches, checks, cyc;
    logic [7:0]      e;

    acmp_ctrl acmp_ctrl_i (.clk_sys(clk_sys), .nrst(nrst),
        .bus_addr(bus_addr), .bus_io(bus_io), .bus_we(bus_we),
        .bus_re(bus_re), .bus_wdata(bus_wdata),
        .bus_rdata_ff(bus_rdata_ff),
        .mux_borrow_enable(mux_borrow_enable),
        .converter_enable(converter_enable),
        .channel_select(channel_select),
        .global_irq_enable(global_irq_enable), .irq_ack(irq_ack),
        .cmp_raw(cmp_raw), .neg_use_channel_ff(neg_use_channel_ff),
        .neg_channel_ff(neg_channel_ff), .pos_use_ref_ff(pos_use_ref_ff),
        .comparator_power_off_ff(comparator_power_off_ff),
        .irq_req_ff(irq_req_ff), .capture_in_ff(capture_in_ff),
        .positive_input_pin(positive_input_pin),
        .negative_input_pin(negative_input_pin),
        .pin_input_off_ff(pin_input_off_ff),
        .pin_readback_ff(pin_readback_ff));

    acmp_analog_model acmp_analog_model_i (.clk_sys(clk_sys), .nrst(nrst),
        .pos_level(pos_level), .neg_level(neg_level),
        .chan_level(chan_level), .neg_use_channel(neg_use_channel_ff),
        .neg_channel(neg_channel_ff), .pos_use_ref(pos_use_ref_ff),
        .capture_in(capture_in_ff), .capture_irq_enable(1'b1),
        .capture_count(capture_count), .cmp_raw(cmp_raw),
        .positive_input_pin(positive_input_pin),
        .negative_input_pin(negative_input_pin));

    // ****************************************************************
    // Clock, timeout and tasks
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Cut a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            wrap_up();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wr(input logic io, input logic [7:0] a, d);
        @(negedge clk_sys);
        bus_io    = io;
        bus_addr  = a;
        bus_wdata = d;
        bus_we    = 1'b1;
        @(negedge clk_sys);
        bus_we = 1'b0;
    endtask

    task automatic rd(input logic io, input logic [7:0] a, exp);
        @(negedge clk_sys);
        bus_io   = io;
        bus_addr = a;
        bus_re   = 1'b1;
        @(negedge clk_sys);
        bus_re = 1'b0;
        chk(bus_rdata_ff, exp);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {nrst, bus_io, bus_we, bus_re, irq_ack, global_irq_enable} = '0;
        {mux_borrow_enable, converter_enable, channel_select} = '0;
        {bus_addr, bus_wdata, cyc, mismatches, checks} = '0;
        pos_level  = 8'h10;
        neg_level  = 8'h80;
        chan_level = {8{8'hFF}};
        idle(8);
        nrst = 1'b1;
        rd(1'b0, ACMP_CSR_ADDR, 8'h00);
        rd(1'b0, ACMP_DIS_ADDR, 8'h00);
        rd(1'b0, 8'h51, 8'h00);
        $display("test reset done");
        // Borrowed channel sweep, then converter on and borrow off
        mux_borrow_enable = 1'b1;  // channel borrow held on
        for (int c = 0; c < 8; c++) begin
            channel_select = 3'(c);
            idle(2);
            chk({7'h00, neg_use_channel_ff}, 8'h01);
            chk({5'h00, neg_channel_ff}, 8'(c));
        end
        converter_enable = 1'b1;
        idle(2);
        chk({4'h0, neg_use_channel_ff, neg_channel_ff}, 8'h00);
        {mux_borrow_enable, converter_enable} = 2'b00;
        idle(2);
        chk({7'h00, neg_use_channel_ff}, 8'h00);
        $display("test steering done");
        // I/O alias of the control register
        wr(1'b1, ACMP_CSR_IO_ADDR, 8'h03);
        rd(1'b0, ACMP_CSR_ADDR, 8'h03);
        rd(1'b1, ACMP_CSR_IO_ADDR, 8'h03);
        wr(1'b0, 8'h30, 8'h00);
        rd(1'b0, ACMP_CSR_ADDR, 8'h03);
        $display("test address done");
        // Every edge code against one rise and one fall
        for (int c = 0; c < 4; c++) begin
            wr(1'b0, ACMP_CSR_ADDR, 8'h10 | 8'(c));
            idle(6);
            rd(1'b0, ACMP_CSR_ADDR, 8'(c));
            pos_level = 8'hF0;
            idle(6);
            e = (c == 0 || c == 3) ? 8'h30 : 8'h20;
            rd(1'b0, ACMP_CSR_ADDR, e | 8'(c));
            wr(1'b0, ACMP_CSR_ADDR, 8'h10 | 8'(c));
            pos_level = 8'h10;
            idle(6);
            e = (c == 0 || c == 2) ? 8'h10 : 8'h00;
            rd(1'b0, ACMP_CSR_ADDR, e | 8'(c));
        end
        $display("test edges done");
        // Bandgap on the positive input
        wr(1'b0, ACMP_CSR_ADDR, 8'h50);
        idle(6);
        chk({7'h00, pos_use_ref_ff}, 8'h01);
        rd(1'b0, ACMP_CSR_ADDR, 8'h70);
        neg_level = 8'hE0;
        idle(6);
        rd(1'b0, ACMP_CSR_ADDR, 8'h50);
        $display("test reference done");
        // Interrupt gating, write-zero keeps flag, vector entry clears
        wr(1'b0, ACMP_CSR_ADDR, 8'h18);
        pos_level = 8'hF0;
        neg_level = 8'h80;
        idle(6);
        chk({7'h00, irq_req_ff}, 8'h00);
        wr(1'b0, ACMP_CSR_ADDR, 8'h08);
        rd(1'b0, ACMP_CSR_ADDR, 8'h38);
        global_irq_enable = 1'b1;
        idle(3);
        chk({7'h00, irq_req_ff}, 8'h01);
        irq_ack = 1'b1;
        idle(1);
        irq_ack = 1'b0;
        idle(3);
        chk({7'h00, irq_req_ff}, 8'h00);
        rd(1'b0, ACMP_CSR_ADDR, 8'h28);
        // Fresh event while both enables stand raises the request
        pos_level = 8'h10;
        idle(5);
        chk({7'h00, irq_req_ff}, 8'h01);
        wr(1'b0, ACMP_CSR_ADDR, 8'h10);
        idle(2);
        chk({7'h00, irq_req_ff}, 8'h00);
        rd(1'b0, ACMP_CSR_ADDR, 8'h00);
        pos_level = 8'hF0;
        global_irq_enable = 1'b0;
        $display("test interrupt done");
        // Capture route on, then off
        wr(1'b0, ACMP_CSR_ADDR, 8'h04);
        idle(3);
        chk({7'h00, capture_in_ff}, 8'h01);
        pos_level = 8'h10;
        idle(6);
        chk({7'h00, capture_in_ff}, 8'h00);
        wr(1'b0, ACMP_CSR_ADDR, 8'h00);
        pos_level = 8'hF0;
        idle(6);
        chk({7'h00, capture_in_ff}, 8'h00);
        chk(capture_count, 8'h01);
        $display("test capture done");
        // Power off bit reaches its output
        wr(1'b0, ACMP_CSR_ADDR, 8'h90);
        idle(2);
        chk({7'h00, comparator_power_off_ff}, 8'h01);
        rd(1'b0, ACMP_CSR_ADDR, 8'hA0);
        $display("test power done");
        // Digital input disable and pin readback
        neg_level = 8'hF0;
        idle(5);
        chk({6'h00, pin_readback_ff}, 8'h03);
        wr(1'b0, ACMP_DIS_ADDR, 8'hFF);
        rd(1'b0, ACMP_DIS_ADDR, 8'h03);
        idle(5);
        chk({6'h00, pin_input_off_ff}, 8'h03);
        chk({6'h00, pin_readback_ff}, 8'h00);
        wr(1'b0, ACMP_DIS_ADDR, 8'h01);
        idle(5);
        chk({6'h00, pin_readback_ff}, 8'h02);
        $display("test pins done");
        wrap_up();
    end
endmodule // acmp_ctrl_tb_top

`default_nettype wire
